/* rtl/dmm_pkg.sv */
package dmm_pkg;

  // clock and measurement timing
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned SMP_REF_HZ   = 16_000_000;
  localparam int unsigned SMP_REF_DIV  = 64;
  localparam int unsigned SMP_TICK_CYC = (CLK_HZ * SMP_REF_DIV) / SMP_REF_HZ;
  localparam int unsigned OVS_STEP_HZ  = 200_000;
  localparam int unsigned OVS_WIN_CYC  = CLK_HZ / OVS_STEP_HZ;
  localparam int unsigned TMR_W       = 8;

  // register indices; byte address is four times the index
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned IDX_W    = 8;
  localparam logic [IDX_W-1:0] IDX_DIAG_SELECT_CH5_CH6    = 8'h2A;
  localparam logic [IDX_W-1:0] IDX_DIAG_SELECT_CH7_CH8    = 8'h2B;
  localparam logic [IDX_W-1:0] IDX_OPEN_CIRCUIT_QUEUE_LEN = 8'h2C;
  localparam logic [IDX_W-1:0] IDX_SAMPLE_OSC_COUNTER     = 8'h2D;
  localparam logic [IDX_W-1:0] IDX_OVERSAMPLE_OSC_COUNTER = 8'h2E;
  localparam logic [IDX_W-1:0] IDX_IDENTIFICATION         = 8'h2F;

  // field layout
  localparam int unsigned REG_W      = 8;
  localparam int unsigned SEL_W      = 3;
  localparam int unsigned SEL_HI_LSB = 3;
  localparam int unsigned SEL_LO_LSB = 0;
  localparam int unsigned ID_W       = 4;
  localparam int unsigned ID_DEV_LSB = 4;
  localparam int unsigned ID_REV_LSB = 0;
  localparam int unsigned NUM_CH     = 8;

  // reset values
  localparam logic [REG_W-1:0] RST_DIAG_SELECT = 8'h00;
  localparam logic [REG_W-1:0] RST_QUEUE_LEN   = 8'h00;
  localparam logic [REG_W-1:0] RST_COUNT       = 8'h00;

  // open detect queue codes
  localparam logic [REG_W-1:0] QUEUE_OFF    = 8'h00;
  localparam logic [REG_W-1:0] QUEUE_MANUAL = 8'h01;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;
  localparam logic       HRESP_OKAY    = 1'b0;

  // diagnostic source codes
  typedef enum logic [2:0] {
    DMM_SRC_PIN        = 3'b000,
    DMM_SRC_DIE_TEMP   = 3'b001,
    DMM_SRC_REF_X4     = 3'b010,
    DMM_SRC_ANALOG_REG = 3'b011,
    DMM_SRC_DIG_REG    = 3'b100,
    DMM_SRC_IF_SUPPLY  = 3'b101,
    DMM_SRC_ANALOG_GND = 3'b110,
    DMM_SRC_ASUPPLY    = 3'b111
  } dmm_src_e;

  // bus data phase
  typedef enum logic [1:0] {
    DMM_DP_IDLE  = 2'b00,
    DMM_DP_WRITE = 2'b01,
    DMM_DP_READ  = 2'b10
  } dmm_dp_e;

endpackage : dmm_pkg

/* rtl/dmm_regs.sv */
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module dmm_regs
  import dmm_pkg::*;
#(
  // arbitrary identification values
  parameter logic [ID_W-1:0] PART_ID      = 4'hA,
  parameter logic [ID_W-1:0] SILICON_REV  = 4'h3,
  parameter int unsigned     QUEUE_W      = 8
)
(
  // clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ce,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output var  logic [31:0]       hrdata,
  output var  logic              hreadyout,
  output var  logic              hresp,
  // diagnostic mux controls
  output var  logic [SEL_W-1:0]  chan5_source_select,
  output var  logic [SEL_W-1:0]  chan6_source_select,
  output var  logic [SEL_W-1:0]  chan7_source_select,
  output var  logic [SEL_W-1:0]  chan8_source_select,
  output var  logic [31:0]       diag_route_onehot,
  // open circuit detection
  input  wire logic              conv_done,
  input  wire logic [NUM_CH-1:0] codes_unchanged,
  output var  logic [NUM_CH-1:0] open_check_en,
  output var  logic              open_detect_manual,
  // oscillators, asynchronous to clk
  input  wire logic              sample_rate_osc,
  input  wire logic              oversampling_osc
);

  localparam int unsigned ROUTE_W = 8;
  localparam logic [TMR_W-1:0] SMP_TICK_LAST = TMR_W'(SMP_TICK_CYC - 1);
  localparam logic [TMR_W-1:0] OVS_WIN_LAST  = TMR_W'(OVS_WIN_CYC - 1);
  localparam logic [TMR_W-1:0] TMR_ZERO     = '0;
  localparam logic [QUEUE_W-1:0] RUN_ZERO   = '0;

  // registers
  logic [REG_W-1:0] diag_select_ch5_ch6;
  logic [REG_W-1:0] diag_select_ch7_ch8;
  logic [REG_W-1:0] open_circuit_queue_len;
  logic [REG_W-1:0] sample_osc_count;
  logic [REG_W-1:0] oversample_osc_count;
  logic [REG_W-1:0] identification;

  // bus state
  dmm_dp_e          dphase;
  logic [IDX_W-1:0] dp_idx;
  logic             addr_ok;
  logic             addr_go;
  logic [IDX_W-1:0] addr_idx;
  logic             wr_now;
  logic [REG_W-1:0] wr_byte;
  logic [REG_W-1:0] next_rdata;

  // oscillator synchronisers
  logic smp_meta;
  logic smp_sync;
  logic smp_last;
  logic ovs_meta;
  logic ovs_sync;
  logic ovs_last;
  logic smp_rise;
  logic ovs_rise;

  // timebases
  logic [TMR_W-1:0] smp_tick_tmr;
  logic [TMR_W-1:0] ovs_win_tmr;
  logic             smp_tick;
  logic             ovs_win_start;

  // open detect
  logic                queue_auto;
  logic [QUEUE_W-1:0]  run_cnt [NUM_CH];

  // address phase decode
  assign addr_ok  = hready && hsel &&
                    (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign addr_idx = haddr[ADDR_LSB +: IDX_W];
  assign addr_go  = addr_ok && (haddr[31:ADDR_LSB+IDX_W] == '0);
  assign wr_now   = (dphase == DMM_DP_WRITE);
  assign wr_byte  = hwdata[REG_W-1:0];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dphase <= DMM_DP_IDLE;
      dp_idx <= '0;
    end
    else if (ce)
    begin
      if (hready)
      begin
        if (addr_ok)
          dphase <= hwrite ? DMM_DP_WRITE : DMM_DP_READ;
        else
          dphase <= DMM_DP_IDLE;
        dp_idx <= addr_go ? addr_idx : '1;
      end
    end
  end

  // zero wait states; every answer is okay
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
    else if (ce)
    begin
      hreadyout <= 1'b1;
      hresp     <= HRESP_OKAY;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      diag_select_ch5_ch6 <= RST_DIAG_SELECT;
    else if (ce && wr_now && dp_idx == IDX_DIAG_SELECT_CH5_CH6)
      diag_select_ch5_ch6 <= {2'b00, wr_byte[SEL_HI_LSB +: SEL_W],
                              wr_byte[SEL_LO_LSB +: SEL_W]};
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      diag_select_ch7_ch8 <= RST_DIAG_SELECT;
    else if (ce && wr_now && dp_idx == IDX_DIAG_SELECT_CH7_CH8)
      diag_select_ch7_ch8 <= {2'b00, wr_byte[SEL_HI_LSB +: SEL_W],
                              wr_byte[SEL_LO_LSB +: SEL_W]};
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      open_circuit_queue_len <= RST_QUEUE_LEN;
    else if (ce && wr_now && dp_idx == IDX_OPEN_CIRCUIT_QUEUE_LEN)
      open_circuit_queue_len <= wr_byte;
  end

  assign identification = {PART_ID, SILICON_REV};

  // read mux; forwards a write in its data phase so back-to-back
  // write then read of one register returns the new value
  always_comb
  begin
    next_rdata = '0;
    case (addr_idx)
      IDX_DIAG_SELECT_CH5_CH6:
        next_rdata = (wr_now && dp_idx == addr_idx)
                     ? {2'b00, wr_byte[SEL_W*2-1:0]} : diag_select_ch5_ch6;
      IDX_DIAG_SELECT_CH7_CH8:
        next_rdata = (wr_now && dp_idx == addr_idx)
                     ? {2'b00, wr_byte[SEL_W*2-1:0]} : diag_select_ch7_ch8;
      IDX_OPEN_CIRCUIT_QUEUE_LEN:
        next_rdata = (wr_now && dp_idx == addr_idx)
                     ? wr_byte : open_circuit_queue_len;
      IDX_SAMPLE_OSC_COUNTER:
        next_rdata = sample_osc_count;
      IDX_OVERSAMPLE_OSC_COUNTER:
        next_rdata = oversample_osc_count;
      IDX_IDENTIFICATION:
        next_rdata = identification;
      default:
        next_rdata = '0;
    endcase
    if (!addr_go || hwrite)
      next_rdata = '0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      hrdata <= '0;
    else if (ce && hready)
      hrdata <= {24'h000000, next_rdata};
  end

  // select outputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chan5_source_select <= DMM_SRC_PIN;
      chan6_source_select <= DMM_SRC_PIN;
      chan7_source_select <= DMM_SRC_PIN;
      chan8_source_select <= DMM_SRC_PIN;
    end
    else if (ce)
    begin
      chan5_source_select <= diag_select_ch5_ch6[SEL_LO_LSB +: SEL_W];
      chan6_source_select <= diag_select_ch5_ch6[SEL_HI_LSB +: SEL_W];
      chan7_source_select <= diag_select_ch7_ch8[SEL_LO_LSB +: SEL_W];
      chan8_source_select <= diag_select_ch7_ch8[SEL_HI_LSB +: SEL_W];
    end
  end

  // code zero closes the pin switch
  function automatic logic [ROUTE_W-1:0] route_of(input logic [SEL_W-1:0] sel);
    logic [ROUTE_W-1:0] r;
    r = '0;
    case (dmm_src_e'(sel))
      DMM_SRC_PIN:        r[DMM_SRC_PIN]        = 1'b1;
      DMM_SRC_DIE_TEMP:   r[DMM_SRC_DIE_TEMP]   = 1'b1;
      DMM_SRC_REF_X4:     r[DMM_SRC_REF_X4]     = 1'b1;
      DMM_SRC_ANALOG_REG: r[DMM_SRC_ANALOG_REG] = 1'b1;
      DMM_SRC_DIG_REG:    r[DMM_SRC_DIG_REG]    = 1'b1;
      DMM_SRC_IF_SUPPLY:  r[DMM_SRC_IF_SUPPLY]  = 1'b1;
      DMM_SRC_ANALOG_GND: r[DMM_SRC_ANALOG_GND] = 1'b1;
      DMM_SRC_ASUPPLY:    r[DMM_SRC_ASUPPLY]    = 1'b1;
      default:            r[DMM_SRC_PIN]        = 1'b1;
    endcase
    return r;
  endfunction : route_of

  // decoded from the register, not the select outputs, so route and
  // select outputs change on the same edge
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      diag_route_onehot <= {4{route_of(DMM_SRC_PIN)}};
    else if (ce)
      diag_route_onehot <= {route_of(diag_select_ch7_ch8[SEL_HI_LSB +: SEL_W]),
                            route_of(diag_select_ch7_ch8[SEL_LO_LSB +: SEL_W]),
                            route_of(diag_select_ch5_ch6[SEL_HI_LSB +: SEL_W]),
                            route_of(diag_select_ch5_ch6[SEL_LO_LSB +: SEL_W])};
  end

  // two or more arms automatic checking
  assign queue_auto = (open_circuit_queue_len != QUEUE_OFF) &&
                      (open_circuit_queue_len != QUEUE_MANUAL);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      open_detect_manual <= 1'b0;
    else if (ce)
      open_detect_manual <= (open_circuit_queue_len == QUEUE_MANUAL);
  end

  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_open
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
        run_cnt[ch] <= RUN_ZERO;
      else if (ce)
      begin
        if (!queue_auto)
          run_cnt[ch] <= RUN_ZERO;
        else if (conv_done)
        begin
          if (!codes_unchanged[ch])
            run_cnt[ch] <= RUN_ZERO;
          else if (run_cnt[ch] < open_circuit_queue_len)
            run_cnt[ch] <= run_cnt[ch] + 1'b1;
        end
      end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
        open_check_en[ch] <= 1'b0;
      else if (ce)
        open_check_en[ch] <= queue_auto &&
                             (run_cnt[ch] >= open_circuit_queue_len);
    end
  end

  // oscillator synchronisers; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      smp_meta <= 1'b0;
      smp_sync <= 1'b0;
      smp_last <= 1'b0;
      ovs_meta <= 1'b0;
      ovs_sync <= 1'b0;
      ovs_last <= 1'b0;
    end
    else if (ce)
    begin
      smp_meta <= sample_rate_osc;
      smp_sync <= smp_meta;
      smp_last <= smp_sync;
      ovs_meta <= oversampling_osc;
      ovs_sync <= ovs_meta;
      ovs_last <= ovs_sync;
    end
  end

  assign smp_rise = smp_sync && !smp_last;
  assign ovs_rise = ovs_sync && !ovs_last;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      smp_tick_tmr <= TMR_ZERO;
    else if (ce)
      smp_tick_tmr <= (smp_tick_tmr == SMP_TICK_LAST) ? TMR_ZERO : smp_tick_tmr + 1'b1;
  end

  assign smp_tick = (smp_tick_tmr == SMP_TICK_LAST);

  // 5 us window gives 200 kHz per count
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ovs_win_tmr <= TMR_ZERO;
    else if (ce)
      ovs_win_tmr <= (ovs_win_tmr == OVS_WIN_LAST) ? TMR_ZERO : ovs_win_tmr + 1'b1;
  end

  assign ovs_win_start = (ovs_win_tmr == OVS_WIN_LAST);

  dmm_win_counter #(
    .CNT_W (REG_W)
  ) u_smp_cnt (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .win_start (smp_rise),
    .tick      (smp_tick),
    .count     (sample_osc_count)
  );

  // oscillator edges per window, resets to zero
  // oscillator above half of clk aliases; limited by synchroniser rate
  dmm_win_counter #(
    .CNT_W (REG_W)
  ) u_ovs_cnt (
    .clk       (clk),
    .rst_b     (rst_b),
    .ce        (ce),
    .win_start (ovs_win_start),
    .tick      (ovs_rise),
    .count     (oversample_osc_count)
  );

endmodule : dmm_regs

`default_nettype wire

/* rtl/dmm_win_counter.sv */
`timescale 1ns/1ps
`default_nettype none

module dmm_win_counter
  import dmm_pkg::*;
#(
  parameter int unsigned CNT_W = 8
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  // window and events
  input  wire logic             win_start,
  input  wire logic             tick,
  // result
  output var  logic [CNT_W-1:0] count
);

  localparam logic [CNT_W-1:0] CNT_MAX  = '1;
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_ZERO + 1'b1;

  logic [CNT_W-1:0] acc;

  // saturates rather than wraps so a fast source never reads as slow
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      acc <= CNT_ZERO;
    else if (ce)
    begin
      if (win_start)
        acc <= tick ? CNT_ONE : CNT_ZERO;
      else if (tick && acc != CNT_MAX)
        acc <= acc + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count <= CNT_ZERO;
    else if (ce && win_start)
      count <= acc;
  end

endmodule : dmm_win_counter

`default_nettype wire

/* tb/dmm_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none

module dmm_regs_props
  import dmm_pkg::*;
#(
  parameter logic [ID_W-1:0] PART_ID     = 4'hA,
  parameter logic [ID_W-1:0] SILICON_REV = 4'h3
)
(
  // clock and bus
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              ce,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic [31:0]       hrdata,
  // mux and open detect
  input wire logic [SEL_W-1:0]  chan5_source_select,
  input wire logic [SEL_W-1:0]  chan6_source_select,
  input wire logic [SEL_W-1:0]  chan7_source_select,
  input wire logic [SEL_W-1:0]  chan8_source_select,
  input wire logic [31:0]       diag_route_onehot,
  input wire logic              conv_done,
  input wire logic [NUM_CH-1:0] open_check_en,
  input wire logic              open_detect_manual
);
  localparam logic [31:0] A_S56 = {22'h0, IDX_DIAG_SELECT_CH5_CH6, 2'b00};
  localparam logic [31:0] A_S78 = {22'h0, IDX_DIAG_SELECT_CH7_CH8, 2'b00};
  localparam logic [31:0] A_QUE = {22'h0, IDX_OPEN_CIRCUIT_QUEUE_LEN, 2'b00};
  localparam logic [31:0] A_ID  = {22'h0, IDX_IDENTIFICATION, 2'b00};

  // data phase tracker; ce low freezes the bus as well
  logic        dp_wr;
  logic        dp_rd;
  logic [31:0] dp_addr;
  wire  logic  wr_done = dp_wr && ce && hready;
  wire  logic  rd_done = dp_rd && ce && hready;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dp_wr   <= 1'b0;
      dp_rd   <= 1'b0;
      dp_addr <= 32'h0;
    end
    else if (ce && hready)
    begin
      dp_wr   <= hsel && htrans[1] && hwrite;
      dp_rd   <= hsel && htrans[1] && !hwrite;
      dp_addr <= haddr;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_sel56_copy: assert property (
    wr_done && dp_addr == A_S56 |=> ##1
    {chan6_source_select, chan5_source_select} == $past(hwdata[5:0], 2))
    else $error("channel 5/6 select copy wrong");
  a_sel78_copy: assert property (
    wr_done && dp_addr == A_S78 |=> ##1
    {chan8_source_select, chan7_source_select} == $past(hwdata[5:0], 2))
    else $error("channel 7/8 select copy wrong");
  a_route_map: assert property (
    diag_route_onehot == {8'h01 << chan8_source_select, 8'h01 << chan7_source_select,
                          8'h01 << chan6_source_select, 8'h01 << chan5_source_select})
    else $error("route switches disagree with selects");
  a_sel_reserved: assert property (
    rd_done && (dp_addr == A_S56 || dp_addr == A_S78) |-> hrdata[31:6] == 26'h0)
    else $error("select read shows reserved bits");
  a_id_fixed: assert property (
    rd_done && dp_addr == A_ID |-> hrdata == {24'h0, PART_ID, SILICON_REV})
    else $error("identification read wrong");
  a_manual_flag: assert property (
    wr_done && dp_addr == A_QUE |=> ##1
    open_detect_manual == ($past(hwdata[7:0], 2) == 8'h01))
    else $error("manual flag does not follow queue");
  a_queue_off: assert property (
    wr_done && dp_addr == A_QUE && hwdata[7:0] == 8'h00 |=> ##1
    (open_check_en == 8'h00) [*4])
    else $error("open check enabled with queue zero");
  a_arm_cause: assert property (
    (open_check_en & ~$past(open_check_en)) != 8'h00 |->
    $past(conv_done) || $past(conv_done, 2))
    else $error("open check armed without conversion");

endmodule : dmm_regs_props

bind dmm_regs dmm_regs_props #(
  .PART_ID     (PART_ID),
  .SILICON_REV (SILICON_REV)
) i_props (
  .clk                 (clk),
  .rst_b               (rst_b),
  .ce                  (ce),
  .hsel                (hsel),
  .haddr               (haddr),
  .htrans              (htrans),
  .hwrite              (hwrite),
  .hwdata              (hwdata),
  .hready              (hready),
  .hrdata              (hrdata),
  .chan5_source_select (chan5_source_select),
  .chan6_source_select (chan6_source_select),
  .chan7_source_select (chan7_source_select),
  .chan8_source_select (chan8_source_select),
  .diag_route_onehot   (diag_route_onehot),
  .conv_done           (conv_done),
  .open_check_en       (open_check_en),
  .open_detect_manual  (open_detect_manual)
);

`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import dmm_pkg::*;
;
  // arbitrary identification values
  localparam logic [ID_W-1:0] ID_P  = 4'h6;
  localparam logic [ID_W-1:0] REV_P = 4'h9;

  logic              clk   = 1'b0;
  logic              rst_b = 1'b0;
  logic              ce    = 1'b1;
  logic              hsel = 1'b0, hwrite = 1'b0, conv_done = 1'b0, osc_on = 1'b0;
  logic [31:0]       haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]        htrans = 2'b00;
  logic [2:0]        hsize  = 3'b010;
  logic [NUM_CH-1:0] codes_unchanged = 8'h00;
  logic [31:0]       hrdata, diag_route_onehot;
  logic              hready, hreadyout, hresp, open_detect_manual;
  logic [SEL_W-1:0]  chan5_source_select, chan6_source_select;
  logic [SEL_W-1:0]  chan7_source_select, chan8_source_select;
  logic [NUM_CH-1:0] open_check_en;
  logic              sample_rate_osc, oversampling_osc;
  int                bad_count = 0, checks_done = 0, osc_cyc = 0;

  assign hready = hreadyout;
  // oscillators locked to clk so the expected counts are exact
  assign oversampling_osc = osc_on && (osc_cyc % 20 < 10);
  assign sample_rate_osc  = osc_on && (osc_cyc % 800 < 400);
  always @(posedge clk) osc_cyc <= osc_on ? osc_cyc + 1 : 0;

  dmm_regs #(.PART_ID(ID_P), .SILICON_REV(REV_P)) i_dut (
    .clk                 (clk),
    .rst_b               (rst_b),
    .ce                  (ce),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hready),
    .hrdata              (hrdata),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .chan5_source_select (chan5_source_select),
    .chan6_source_select (chan6_source_select),
    .chan7_source_select (chan7_source_select),
    .chan8_source_select (chan8_source_select),
    .diag_route_onehot   (diag_route_onehot),
    .conv_done           (conv_done),
    .codes_unchanged     (codes_unchanged),
    .open_check_en       (open_check_en),
    .open_detect_manual  (open_detect_manual),
    .sample_rate_osc     (sample_rate_osc),
    .oversampling_osc    (oversampling_osc)
  );

  initial
  begin
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] ba(input logic [IDX_W-1:0] i);
    return {22'h0, i, 2'b00};
  endfunction : ba

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : check

  // entered just after a rising edge; one single transfer
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr_reg

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(n, e, q);
    check("resp", 32'h0, {31'h0, hresp});
  endtask : rd_chk

  task automatic conv(input logic [NUM_CH-1:0] p);
    conv_done       <= 1'b1;
    codes_unchanged <= p;
    @(posedge clk);
    conv_done <= 1'b0;
    @(posedge clk);
  endtask : conv

  task automatic report_and_stop();
    $display("mismatches %0d, comparisons %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // run takes about 2650 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    logic [2:0] c;
    logic [2:0] d;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check("route", 32'h01010101, diag_route_onehot);
    for (int i = 0; i < 5; i++) rd_chk(ba(IDX_DIAG_SELECT_CH5_CH6 + 8'(i)), 32'h0, "reset");
    rd_chk(ba(IDX_IDENTIFICATION), {24'h0, ID_P, REV_P}, "id");
    // writes to read-only places and one unmapped index
    for (int i = 3; i < 7; i++) wr_reg(ba(IDX_DIAG_SELECT_CH5_CH6 + 8'(i)), 32'hFFFF_FFFF);
    rd_chk(ba(IDX_SAMPLE_OSC_COUNTER), 32'h0, "smp ro");
    rd_chk(ba(IDX_OVERSAMPLE_OSC_COUNTER), 32'h0, "ovs ro");
    // range choice for diagnostic sources is software's, outside this block
    rd_chk(ba(IDX_IDENTIFICATION), {24'h0, ID_P, REV_P}, "id ro");
    rd_chk(ba(8'h30), 32'h0, "unmapped");
    for (int i = 0; i < 8; i++)
    begin
      c = 3'(i);
      d = ~c;
      wr_reg(ba(IDX_DIAG_SELECT_CH5_CH6), {24'h0, 2'b11, d, c});
      wr_reg(ba(IDX_DIAG_SELECT_CH7_CH8), {24'h0, 2'b11, c, d});
      rd_chk(ba(IDX_DIAG_SELECT_CH5_CH6), {26'h0, d, c}, "sel56");
      rd_chk(ba(IDX_DIAG_SELECT_CH7_CH8), {26'h0, c, d}, "sel78");
      check("selects", {20'h0, c, d, d, c}, {20'h0, chan8_source_select,
            chan7_source_select, chan6_source_select, chan5_source_select});
      check("route", {8'h01 << c, 8'h01 << d, 8'h01 << d, 8'h01 << c}, diag_route_onehot);
    end
    // enable low freezes the bus, so this write must not land
    ce <= 1'b0;
    wr_reg(ba(IDX_DIAG_SELECT_CH5_CH6), 32'h3F);
    ce <= 1'b1;
    rd_chk(ba(IDX_DIAG_SELECT_CH5_CH6), 32'h07, "frozen");
    wr_reg(ba(IDX_OPEN_CIRCUIT_QUEUE_LEN), 32'h01);
    repeat (3) @(posedge clk);
    check("manual", 32'h1, {31'h0, open_detect_manual});
    wr_reg(ba(IDX_OPEN_CIRCUIT_QUEUE_LEN), 32'h03);
    conv(8'hFF);
    conv(8'hFD);
    check("manual off", 32'h0, {31'h0, open_detect_manual});
    check("not armed", 32'h0, {24'h0, open_check_en});
    conv(8'hFF);
    @(posedge clk);
    check("armed", 32'hFD, {24'h0, open_check_en});
    rd_chk(ba(IDX_OPEN_CIRCUIT_QUEUE_LEN), 32'h03, "queue");
    wr_reg(ba(IDX_OPEN_CIRCUIT_QUEUE_LEN), 32'h00);
    repeat (3) conv(8'hFF);
    check("disabled", 32'h0, {24'h0, open_check_en});
    osc_on <= 1'b1;
    repeat (2500) @(posedge clk);
    rd_chk(ba(IDX_SAMPLE_OSC_COUNTER), 32'(800 / SMP_TICK_CYC), "smp count");
    rd_chk(ba(IDX_OVERSAMPLE_OSC_COUNTER), 32'(CLK_HZ / 20 / OVS_STEP_HZ), "ovs count");
    // second reset in mid-run, oscillators still running
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_chk(ba(IDX_OVERSAMPLE_OSC_COUNTER), 32'h0, "ovs reset");
    rd_chk(ba(IDX_DIAG_SELECT_CH5_CH6), 32'h0, "sel reset");
    check("route reset", 32'h01010101, diag_route_onehot);
    report_and_stop();
  end

endmodule : tb_top

`default_nettype wire
